/* cmc_pkg.sv */
// Package for the CAN transceiver mode control block
package cmc_pkg;

  // Interface mode as commanded over the serial port
  typedef enum logic [0:0] {
    CMC_MODE_NORMAL = 1'b0,
    CMC_MODE_SLEEP  = 1'b1
  } cmc_mode_t;

  // System basis device modes seen by the interface
  typedef enum logic [2:0] {
    CMC_SYS_RESET       = 3'b000,
    CMC_SYS_NORM_REQ    = 3'b001,
    CMC_SYS_NORMAL      = 3'b010,
    CMC_SYS_STANDBY     = 3'b011,
    CMC_SYS_SLEEP       = 3'b100,
    CMC_SYS_STOP        = 3'b101
  } cmc_sys_t;

  // Driver states on the bus lines
  typedef enum logic [1:0] {
    CMC_BUS_FLOAT     = 2'b00,
    CMC_BUS_RECESSIVE = 2'b01,
    CMC_BUS_DOMINANT  = 2'b10,
    CMC_BUS_WEAK_GND  = 2'b11
  } cmc_bus_t;

  // Settings written by the serial port
  typedef struct packed {
    cmc_mode_t  mode;
    logic [1:0] slew;
    logic       wake_en;
  } cmc_cfg_t;

  // Status returned to the serial port
  typedef struct packed {
    logic       transmit_failure_flag;
    logic       bus_wake;
    logic       driver_off;
  } cmc_stat_t;

  localparam logic [1:0] CMC_SLEW_RESET    = 2'h0;
  localparam logic       CMC_WAKE_EN_RESET = 1'b0;

  // Clock and timing
  localparam int CMC_CLK_MHZ         = 200;
  localparam int CMC_TDOM_US         = 200;
  localparam int CMC_TDOM_CYC        = CMC_TDOM_US * CMC_CLK_MHZ;
  localparam int CMC_WK_PULSE_MIN_NS = 500;
  localparam int CMC_WK_PULSE_MIN_CYC = (CMC_WK_PULSE_MIN_NS * CMC_CLK_MHZ + 999) / 1000;
  localparam int CMC_WK_PULSE_MAX_US = 500;
  localparam int CMC_WK_PULSE_MAX_CYC = CMC_WK_PULSE_MAX_US * CMC_CLK_MHZ;
  localparam int CMC_WK_GAP_MAX_US   = 500;
  localparam int CMC_WK_GAP_MAX_CYC  = CMC_WK_GAP_MAX_US * CMC_CLK_MHZ;
  localparam int CMC_WK_WIN_US       = 1000;
  localparam int CMC_WK_WIN_CYC      = CMC_WK_WIN_US * CMC_CLK_MHZ;
  localparam int CMC_WK_PULSES       = 3;

endpackage : cmc_pkg

/* cmc_wake_det.sv */
// Bus pattern wake-up detector: three valid dominant pulses within a window
`timescale 1ns/1ps
`default_nettype none
module cmc_wake_det #(
  parameter int PULSE_MIN = cmc_pkg::CMC_WK_PULSE_MIN_CYC,
  parameter int PULSE_MAX = cmc_pkg::CMC_WK_PULSE_MAX_CYC,
  parameter int GAP_MAX   = cmc_pkg::CMC_WK_GAP_MAX_CYC,
  parameter int WIN_MAX   = cmc_pkg::CMC_WK_WIN_CYC,
  parameter int NPULSE    = cmc_pkg::CMC_WK_PULSES
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Control
  input  wire logic enable_i,
  input  wire logic bus_dom_i,
  // Result
  output logic      wake_o
);
  import cmc_pkg::*;

  logic [31:0] pulse_cnt;
  logic [31:0] gap_cnt;
  logic [31:0] win_cnt;
  logic [1:0]  n_ok;
  logic        dom_q;
  logic        seen;
  logic        fall;
  logic        good;

  assign fall = dom_q && !bus_dom_i;
  assign good = (pulse_cnt > 32'(PULSE_MIN)) && (pulse_cnt < 32'(PULSE_MAX));

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !enable_i) begin
      dom_q <= 1'b0;
    end else begin
      dom_q <= bus_dom_i;
    end
  end

  // Length of the current dominant pulse and of the recessive gap
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !enable_i) begin
      pulse_cnt <= 32'h0000_0000;
      gap_cnt   <= 32'h0000_0000;
    end else if (bus_dom_i) begin
      pulse_cnt <= (pulse_cnt == 32'hFFFF_FFFF) ? pulse_cnt : pulse_cnt + 32'h0000_0001;
      gap_cnt   <= 32'h0000_0000;
    end else begin
      pulse_cnt <= 32'h0000_0000;
      gap_cnt   <= (gap_cnt == 32'hFFFF_FFFF) ? gap_cnt : gap_cnt + 32'h0000_0001;
    end
  end

  // Pulse tally; any invalid pulse, long gap or window overrun restarts it
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !enable_i) begin
      n_ok    <= 2'h0;
      seen    <= 1'b0;
      win_cnt <= 32'h0000_0000;
      wake_o  <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      if (seen) begin
        win_cnt <= win_cnt + 32'h0000_0001;
      end
      if (fall) begin
        if (good && !(seen && win_cnt >= 32'(WIN_MAX))) begin
          if (n_ok == 2'(NPULSE - 1)) begin
            wake_o  <= 1'b1; // RULE18
            n_ok    <= 2'h0;
            seen    <= 1'b0;
            win_cnt <= 32'h0000_0000;
          end else begin
            n_ok <= n_ok + 2'h1;
            if (!seen) begin
              seen    <= 1'b1;
              win_cnt <= pulse_cnt;
            end
          end
        end else begin
          n_ok    <= 2'h0;
          seen    <= 1'b0;
          win_cnt <= 32'h0000_0000;
        end
      end else if (seen && !bus_dom_i && gap_cnt >= 32'(GAP_MAX)) begin
        n_ok    <= 2'h0; // RULE18
        seen    <= 1'b0;
        win_cnt <= 32'h0000_0000;
      end
    end
  end

endmodule : cmc_wake_det
`default_nettype wire

/* cmc_ctrl.sv */
// CAN transceiver mode control: modes, driver, receive pin, timeout, wake-up
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - Two modes, normal and sleep, command only (code: also forced by system reset, normal-request, sleep and stop)
// RULE2 - Four slew settings selectable in normal mode
// RULE3 - Wake detection choice made before sleep
// RULE4 - Transmit high gives recessive bus bias
// RULE5 - Transmit low drives bus dominant
// RULE6 - Receive high recessive, low dominant
// RULE7 - Undriven transmit input counts as recessive
// RULE8 - Supply off forces receive output low
// RULE9 - Long dominant transmit switches driver off
// RULE10 - Controller keeps bit rate above sixty kbaud
// RULE11 - Off system modes: pins low, bus floating (code: weak ground in sleep mode, which sleep and stop force)
// RULE12 - Standby without ballast follows interface mode
// RULE13 - Reset defaults: normal mode, slew zero
// RULE14 - Low power disables drivers, weak ground
// RULE15 - Wake receiver only when enabled
// RULE16 - Leaving sleep restores recessive bus
// RULE17 - Sleep allowed with supply on or off
// RULE18 - Wake needs three valid pulses in window
// RULE19 - Failure flag latched until gone and read
// RULE20 - Driver returns when transmit goes high
// RULE21 - Settings apply at next control update
module cmc_ctrl #(
  parameter int TDOM_CYC = cmc_pkg::CMC_TDOM_CYC
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // Serial port settings and status
  input  wire logic                  cfg_we_i,
  input  wire cmc_pkg::cmc_cfg_t     cfg_i,
  input  wire logic                  stat_rd_i,
  output cmc_pkg::cmc_cfg_t          cfg_o,
  output cmc_pkg::cmc_stat_t         stat_o,
  // System context
  input  wire cmc_pkg::cmc_sys_t     sys_mode_i,
  input  wire logic                  ballast_i,
  input  wire logic                  peripheral_supply_i,
  // Controller side pins
  input  wire logic                  tx_drv_i,
  input  wire logic                  tx_oe_i,
  output logic                       rx_o,
  output logic                       tx_level_o,
  // Bus side
  input  wire logic                  bus_dom_i,
  output cmc_pkg::cmc_bus_t          bus_o,
  output logic [1:0]                 slew_o,
  output logic                       wake_rx_en_o,
  output logic                       bus_wake_o
);
  import cmc_pkg::*;

  cmc_cfg_t  shadow;
  logic      shadow_new;
  logic      active;
  logic      sleep_pins_high;
  logic      tx_eff;
  logic      drv_off;
  logic [31:0] dom_cnt;
  logic      wake_pulse;
  logic      wake_en_eff;
  logic      next_tx_fail;
  cmc_bus_t  next_bus;
  logic      next_rx;
  logic      next_txl;

  // Pending serial write, applied on the following cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      shadow     <= '{CMC_MODE_NORMAL, CMC_SLEW_RESET, CMC_WAKE_EN_RESET};
      shadow_new <= 1'b0;
    end else begin
      shadow_new <= cfg_we_i; // RULE21
      if (cfg_we_i) begin
        shadow <= cfg_i;
      end
    end
  end

  // Applied settings; reset restores defaults, normal-request restores default mode and slew but keeps wake_en
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cfg_o <= '{CMC_MODE_NORMAL, CMC_SLEW_RESET, CMC_WAKE_EN_RESET}; // RULE13
    end else if (sys_mode_i == CMC_SYS_RESET || sys_mode_i == CMC_SYS_NORM_REQ) begin
      cfg_o <= '{CMC_MODE_NORMAL, CMC_SLEW_RESET, cfg_o.wake_en}; // RULE13
    end else if (sys_mode_i == CMC_SYS_SLEEP || sys_mode_i == CMC_SYS_STOP) begin
      cfg_o.mode <= CMC_MODE_SLEEP; // RULE11
      if (shadow_new) begin
        cfg_o.wake_en <= shadow.wake_en; // RULE3
        cfg_o.slew    <= shadow.slew;
      end
    end else if (shadow_new) begin
      cfg_o <= shadow; // RULE1 RULE2 RULE3 RULE17
    end
  end

  // Interface is powered for traffic only in these system modes
  always_comb begin
    active          = 1'b0;
    sleep_pins_high = 1'b0;
    unique case (sys_mode_i)
      CMC_SYS_NORMAL: begin
        active          = peripheral_supply_i && (cfg_o.mode == CMC_MODE_NORMAL);
        sleep_pins_high = peripheral_supply_i && (cfg_o.mode == CMC_MODE_SLEEP);
      end
      CMC_SYS_STANDBY: begin
        active          = !ballast_i && peripheral_supply_i
                          && (cfg_o.mode == CMC_MODE_NORMAL); // RULE12
        sleep_pins_high = !ballast_i && peripheral_supply_i
                          && (cfg_o.mode == CMC_MODE_SLEEP); // RULE12
      end
      default: begin
        active          = 1'b0; // RULE11
        sleep_pins_high = 1'b0;
      end
    endcase
  end

  // Pull-up: an undriven transmit pin reads high
  assign tx_eff = tx_oe_i ? tx_drv_i : 1'b1; // RULE7

  // Permanent dominant timer
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !active || tx_eff) begin
      dom_cnt <= 32'h0000_0000;
      drv_off <= 1'b0; // RULE20
    end else if (dom_cnt >= 32'(TDOM_CYC - 1)) begin
      drv_off <= 1'b1; // RULE9
    end else begin
      dom_cnt <= dom_cnt + 32'h0000_0001;
    end
  end

  // Latched failure; a new fault wins over the read clear
  always_comb begin
    next_tx_fail = stat_o.transmit_failure_flag;
    if (stat_rd_i && !drv_off) begin
      next_tx_fail = 1'b0;
    end
    if (drv_off) begin
      next_tx_fail = 1'b1; // RULE19
    end
  end

  // Wake receiver runs only in low power with wake enabled
  assign wake_en_eff = (cfg_o.mode == CMC_MODE_SLEEP) && cfg_o.wake_en; // RULE15

  cmc_wake_det u_wake (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .enable_i   (wake_en_eff),
    .bus_dom_i  (bus_dom_i),
    .wake_o     (wake_pulse)
  );

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      stat_o <= '0;
    end else begin
      stat_o.transmit_failure_flag <= next_tx_fail;
      stat_o.driver_off            <= drv_off;
      if (wake_pulse) begin
        stat_o.bus_wake <= 1'b1;
      end else if (stat_rd_i && cfg_o.mode == CMC_MODE_NORMAL) begin
        stat_o.bus_wake <= 1'b0;
      end
    end
  end

  // Pin and bus state decode
  always_comb begin
    next_bus = CMC_BUS_FLOAT;
    next_rx  = 1'b0; // RULE8 RULE11
    next_txl = 1'b0;
    if (active) begin
      next_txl = tx_eff;
      next_rx  = !bus_dom_i; // RULE6
      if (!tx_eff && !drv_off) begin
        next_bus = CMC_BUS_DOMINANT; // RULE5
      end else begin
        next_bus = CMC_BUS_RECESSIVE; // RULE4 RULE16
      end
    end else if (sleep_pins_high) begin
      next_txl = 1'b1; // RULE12
      next_rx  = 1'b1;
      next_bus = CMC_BUS_WEAK_GND; // RULE14
    end else if (cfg_o.mode == CMC_MODE_SLEEP) begin
      next_bus = CMC_BUS_WEAK_GND; // RULE14
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      bus_o      <= CMC_BUS_FLOAT;
      rx_o       <= 1'b0;
      tx_level_o <= 1'b0;
    end else begin
      bus_o      <= next_bus;
      rx_o       <= next_rx;
      tx_level_o <= next_txl;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      slew_o       <= CMC_SLEW_RESET;
      wake_rx_en_o <= 1'b0;
      bus_wake_o   <= 1'b0;
    end else begin
      slew_o       <= cfg_o.slew; // RULE2
      wake_rx_en_o <= wake_en_eff; // RULE15
      bus_wake_o   <= wake_pulse;
    end
  end

endmodule : cmc_ctrl
`default_nettype wire

/* cmc_ctrl_asserts.sv */
// Concurrent checks on the transceiver mode control ports
`timescale 1ns/1ps
`default_nettype none
module cmc_ctrl_asserts #(
  parameter int TDOM_CYC = cmc_pkg::CMC_TDOM_CYC
) (
  // Clock and reset
  input wire logic               core_clk_i,
  input wire logic               nrst_i,
  // Settings and status
  input wire logic               cfg_we_i,
  input wire cmc_pkg::cmc_cfg_t  cfg_i,
  input wire cmc_pkg::cmc_cfg_t  cfg_o,
  input wire cmc_pkg::cmc_stat_t stat_o,
  // Context
  input wire cmc_pkg::cmc_sys_t  sys_mode_i,
  input wire logic               ballast_i,
  input wire logic               peripheral_supply_i,
  // Pins and bus
  input wire logic               tx_drv_i,
  input wire logic               tx_oe_i,
  input wire logic               bus_dom_i,
  input wire logic               rx_o,
  input wire logic               tx_level_o,
  input wire cmc_pkg::cmc_bus_t  bus_o,
  input wire logic [1:0]         slew_o,
  input wire logic               wake_rx_en_o
);
  import cmc_pkg::*;
  logic act, txh, off, nrm;
  int   cnt;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  assign txh = tx_drv_i | ~tx_oe_i;
  assign nrm = sys_mode_i == CMC_SYS_NORMAL;
  assign act = peripheral_supply_i && cfg_o.mode == CMC_MODE_NORMAL &&
               (nrm || (sys_mode_i == CMC_SYS_STANDBY && !ballast_i));
  assign off = sys_mode_i inside {CMC_SYS_RESET, CMC_SYS_NORM_REQ, CMC_SYS_SLEEP,
               CMC_SYS_STOP} || (sys_mode_i == CMC_SYS_STANDBY && ballast_i);
  // Dominant run length, saturating so it cannot wrap
  always_ff @(posedge core_clk_i)
    if (!nrst_i || !act || txh) cnt <= 0;
    else if (cnt < TDOM_CYC) cnt <= cnt + 1;
  property p_rec; act && txh |=> bus_o == CMC_BUS_RECESSIVE && tx_level_o; endproperty
  a_rec: assert property (p_rec) else $error("no recessive bias");
  property p_dom; act && !txh && !stat_o.driver_off && cnt < TDOM_CYC - 4
    |=> bus_o == CMC_BUS_DOMINANT; endproperty
  a_dom: assert property (p_dom) else $error("no dominant drive");
  property p_rx; act |=> rx_o == !$past(bus_dom_i); endproperty
  a_rx: assert property (p_rx) else $error("receive level wrong");
  property p_sup; !peripheral_supply_i |=> !rx_o; endproperty
  a_sup: assert property (p_sup) else $error("receive high unpowered");
  property p_off; off |=> !rx_o && !tx_level_o; endproperty
  a_off: assert property (p_off) else $error("pins not low");
  // Unpowered interface floats; a sleeping one shows its weak path to ground
  property p_flt; (off || !peripheral_supply_i) && cfg_o.mode == CMC_MODE_NORMAL |=>
    bus_o == CMC_BUS_FLOAT; endproperty
  a_flt: assert property (p_flt) else $error("bus not floating");
  property p_lowp; (off || !peripheral_supply_i) && cfg_o.mode == CMC_MODE_SLEEP |=>
    bus_o == CMC_BUS_WEAK_GND; endproperty
  a_lowp: assert property (p_lowp) else $error("bus not weak to ground");
  property p_sby; sys_mode_i == CMC_SYS_STANDBY && !ballast_i && peripheral_supply_i &&
    cfg_o.mode == CMC_MODE_SLEEP |=> rx_o && tx_level_o && bus_o == CMC_BUS_WEAK_GND;
  endproperty
  a_sby: assert property (p_sby) else $error("standby sleep pins wrong");
  property p_rst; $rose(nrst_i) |-> cfg_o.mode == CMC_MODE_NORMAL && slew_o == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
  property p_cfg; cfg_we_i && nrm ##1 !cfg_we_i && nrm |-> ##1
    cfg_o.slew == $past(cfg_i.slew, 2) ##1 slew_o == $past(cfg_i.slew, 3); endproperty
  a_cfg: assert property (p_cfg) else $error("slew not applied");
  property p_tdom; cnt == TDOM_CYC |-> ##[0:3] stat_o.driver_off; endproperty
  a_tdom: assert property (p_tdom) else $error("driver not cut");
  property p_flag; $rose(stat_o.driver_off) |-> ##[0:2] stat_o.transmit_failure_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("failure not latched");
  property p_back; stat_o.driver_off && txh |-> ##[1:2] !stat_o.driver_off; endproperty
  a_back: assert property (p_back) else $error("driver not restored");
  property p_wk; wake_rx_en_o |-> $past(cfg_o.wake_en) &&
    $past(cfg_o.mode) == CMC_MODE_SLEEP; endproperty
  a_wk: assert property (p_wk) else $error("wake receiver on");
endmodule : cmc_ctrl_asserts
bind cmc_ctrl cmc_ctrl_asserts #(.TDOM_CYC(TDOM_CYC)) chk_u (.*);
`default_nettype wire

/* cmc_mcu_model.sv */
// Controller-side model: drives or releases the transmit pin
`timescale 1ns/1ps
`default_nettype none
module cmc_mcu_model (
  // Clock
  input  wire logic core_clk_i,
  // Requests from the bench
  input  wire logic send_i,
  input  wire logic bit_i,
  // Transmit pin
  output var logic  tx_drv_o = 1'b1,
  output var logic  tx_oe_o = 1'b0
);
  // A released pin shows the pull-up level; runs stay short unless asked
  always @(negedge core_clk_i) begin
    tx_oe_o  <= send_i;
    tx_drv_o <= send_i ? bit_i : 1'b1;
  end
endmodule : cmc_mcu_model
`default_nettype wire

/* cmc_ctrl_test.sv */
// Self-checking bench for the CAN transceiver mode control block
`timescale 1ns/1ps
`default_nettype none
module cmc_ctrl_test;
  import cmc_pkg::*;
  localparam int TDOM = 50;
  logic       clk = 1'b0, nrst = 1'b0, we = 1'b0, rd = 1'b0, bal = 1'b0, sup = 1'b1;
  logic       send = 1'b0, bitv = 1'b1, ext = 1'b0, woke = 1'b0;
  logic       txd, txe, rx, txl, wk, wke, dom;
  logic [1:0] slew;
  cmc_cfg_t   cfg = '0;
  cmc_cfg_t   cfo;
  cmc_stat_t  st;
  cmc_sys_t   sys = CMC_SYS_NORMAL;
  cmc_bus_t   bus;
  int         miscompares = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  assign dom = ext | (bus == CMC_BUS_DOMINANT);
  always @(posedge clk) if (wk) woke <= 1'b1;
  cmc_mcu_model mcu_u (.core_clk_i(clk), .send_i(send), .bit_i(bitv), .tx_drv_o(txd),
    .tx_oe_o(txe));
  cmc_ctrl #(.TDOM_CYC(TDOM)) dut_u (.core_clk_i(clk), .nrst_i(nrst), .cfg_we_i(we),
    .cfg_i(cfg), .stat_rd_i(rd), .cfg_o(cfo), .stat_o(st), .sys_mode_i(sys),
    .ballast_i(bal), .peripheral_supply_i(sup), .tx_drv_i(txd), .tx_oe_i(txe),
    .rx_o(rx), .tx_level_o(txl), .bus_dom_i(dom), .bus_o(bus), .slew_o(slew),
    .wake_rx_en_o(wke), .bus_wake_o(wk));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input cmc_mode_t m, input logic [1:0] s, input logic w);
    @(negedge clk);
    cfg <= '{m, s, w};
    we  <= 1'b1;
    cyc(1);
    we <= 1'b0;
    cyc(4);
  endtask : wr
  task automatic tx(input logic s, input logic b);
    @(negedge clk);
    send <= s;
    bitv <= b;
  endtask : tx
  task automatic rdst;
    @(negedge clk);
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(2);
  endtask : rdst
  task automatic t_modes;
    logic on;
    for (int b = 0; b < 2; b++) begin
      @(negedge clk);
      sys <= CMC_SYS_NORMAL;
      bal <= b[0];
      wr(CMC_MODE_NORMAL, 2'h0, 1'b0);
      for (int m = 0; m < 6; m++) begin
        sys <= cmc_sys_t'(m);
        cyc(5);
        on = (m == 2) || (m == 3 && b == 0);
        // Sleep and stop force the interface asleep, so the bus sits weak to ground
        chk({txl, rx, bus}, {on, on, on ? CMC_BUS_RECESSIVE :
            (m >= 4 ? CMC_BUS_WEAK_GND : CMC_BUS_FLOAT)});
      end
    end
    sys <= CMC_SYS_NORMAL;
    bal <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_slew;
    for (int s = 0; s < 4; s++) begin
      wr(CMC_MODE_NORMAL, s[1:0], 1'b0);
      chk({2'h0, slew}, {2'h0, s[1:0]});
    end
    @(negedge clk);
    cfg <= '{CMC_MODE_NORMAL, 2'h2, 1'b0};
    we  <= 1'b1;
    cyc(1);
    cfg <= '{CMC_MODE_NORMAL, 2'h1, 1'b0};
    cyc(1);
    we <= 1'b0;
    cyc(4);
    chk({2'h0, slew}, 4'h1);
    $display("test slew done");
  endtask : t_slew
  task automatic t_txrx;
    tx(1'b1, 1'b0);
    cyc(4);
    chk({txl, rx, bus}, {2'b00, CMC_BUS_DOMINANT});
    tx(1'b0, 1'b0);
    cyc(4);
    chk({txl, rx, bus}, {2'b11, CMC_BUS_RECESSIVE});
    sup <= 1'b0;
    cyc(3);
    chk({3'h0, rx}, 4'h0);
    sup <= 1'b1;
    $display("test txrx done");
  endtask : t_txrx
  task automatic t_tdom;
    tx(1'b1, 1'b0);
    cyc(TDOM + 6);
    chk({st.driver_off, st.transmit_failure_flag, bus}, {2'b11, CMC_BUS_RECESSIVE});
    rdst;
    chk({3'h0, st.transmit_failure_flag}, 4'h1);
    tx(1'b0, 1'b1);
    cyc(3);
    chk({2'h0, st.driver_off, st.transmit_failure_flag}, 4'h1);
    rdst;
    chk({3'h0, st.transmit_failure_flag}, 4'h0);
    $display("test timeout done");
  endtask : t_tdom
  task automatic t_sleep;
    for (int w = 0; w < 2; w++) begin
      wr(CMC_MODE_SLEEP, 2'h0, w[0]);
      woke = 1'b0;
      chk({3'h0, wke}, {3'h0, w[0]});
      chk({txl, rx, bus}, {2'b11, CMC_BUS_WEAK_GND});
      repeat (3) begin
        ext <= 1'b1;
        cyc(200);
        ext <= 1'b0;
        cyc(200);
      end
      chk({3'h0, woke}, {3'h0, w[0]});
      chk({3'h0, st.bus_wake}, {3'h0, w[0]});
    end
    // Pulses shorter than the minimum must not wake
    woke = 1'b0;
    repeat (3) begin
      ext <= 1'b1;
      cyc(50);
      ext <= 1'b0;
      cyc(50);
    end
    chk({3'h0, woke}, 4'h0);
    sys <= CMC_SYS_STANDBY;
    cyc(4);
    chk({txl, rx, bus}, {2'b11, CMC_BUS_WEAK_GND});
    sys <= CMC_SYS_NORMAL;
    sup <= 1'b0;
    wr(CMC_MODE_NORMAL, 2'h0, 1'b0);
    wr(CMC_MODE_SLEEP, 2'h0, 1'b0);
    chk({cfo.mode, rx, bus}, {CMC_MODE_SLEEP, 1'b0, CMC_BUS_WEAK_GND});
    sup <= 1'b1;
    wr(CMC_MODE_NORMAL, 2'h0, 1'b0);
    chk({txl, rx, bus}, {2'b11, CMC_BUS_RECESSIVE});
    rdst;
    chk({3'h0, st.bus_wake}, 4'h0);
    $display("test sleep done");
  endtask : t_sleep
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    cyc(3);
    nrst <= 1'b1;
    cyc(2);
    chk({cfo.mode, 1'b0, slew}, 4'h0);
    t_modes;
    t_slew;
    t_txrx;
    t_tdom;
    t_sleep;
    give_verdict;
  end
  // All tests need about 3000 cycles; the margin is generous
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
endmodule : cmc_ctrl_test
`default_nettype wire
